/* gen3_pcs_datapath.sv */
// Purpose: Gen3 128b/130b PCS datapath: transmit gearbox, block sync,
//          rate match, rate follow, CDR control and loopback selection.
// Assumes: Every input is synchronous to sys_clk_i; the MAC leaves a gap.
// Notes:   Serial loopback muxes act on single recovered or serial bits.
// Contract
// [RL1] Gearbox turns 130-bit blocks into 32-bit words.
// [RL2] Block arrives as 34, 32, 32, 32 bits.
// [RL3] First word trimmed; later words merge leftovers.
// [RL4] Two-bit shift per block; sixteen give extra word.
// [RL5] MAC drops valid one cycle per sixteen blocks.
// [RL6] Transmit PCS FIFO is phase compensation only.
// [RL7] Core FIFO modes: phase, register, basic.
// [RL8] Sync finds boundary via EIEOS, FTS or SKP; code matches EIEOS and SKP only.
// [RL9] Accept SKP lengths 66..194; realign after each.
// [RL10] SKP fixed part: header, END, LFSR.
// [RL11] Rate match works in four-SKP 32-bit units.
// [RL12] Nearly full: drop SKP word from writes.
// [RL13] Nearly empty: at SKP, pause reads, insert.
// [RL14] Receive core FIFO in phase compensation mode.
// [RL15] Follow MAC rate request: Gen1, Gen2, Gen3.
// [RL16] EIOS forces reference lock; idle exit data lock. Code does this at Gen3 only.
// [RL17] Serial loopback feeds CDR from serializer.
// [RL18] Post-CDR reverse sends recovered data out.
// [RL19] Zero pre-emphasis taps before pre-CDR reverse; code has no taps.
// [RL20] Four exclusive loopback settings, one active.
// [RL21] Gap cycle outputs extra word, resets shift.
`timescale 1ns/100ps
module gen3_pcs_datapath
    import gen3_pcs_pkg::*;
#(
    parameter int unsigned DEPTH      = 8,
    parameter int unsigned NEAR_EMPTY = 2,
    parameter int unsigned NEAR_FULL  = 6
) (
    input  wire logic        sys_clk_i,
    input  wire logic        reset_n_i,
    input  wire apb_req_type apb_i,
    output logic [31:0]      prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    input  wire logic [1:0]  pipe_rate_i,
    input  wire logic [31:0] tx_data_i,
    input  wire logic [1:0]  tx_sync_hdr_i,
    input  wire logic        tx_data_valid_i,
    output logic [31:0]      tx_pma_data_o,
    output logic             tx_pma_valid_o,
    input  wire logic [31:0] rx_pma_data_i,
    input  wire logic        rx_pma_valid_i,
    input  wire logic        rx_elec_idle_i,
    output logic [31:0]      rx_data_o,
    output logic             rx_valid_o,
    output logic             rx_locked_o,
    output logic [1:0]       rate_o,
    output logic             cdr_lock_to_ref_o,
    input  wire logic        ser_bit_i,
    input  wire logic        rx_pin_i,
    input  wire logic        cdr_bit_i,
    output logic             cdr_in_o,
    output logic             tx_buf_o
);

    localparam int unsigned AW = $clog2(DEPTH);

    typedef struct packed {
        logic [63:0]             acc;
        logic [5:0]              fill;
        logic [1:0]              widx;
        logic [31:0]             gb_word;
        logic                    gb_v;
        logic [31:0]             tx_s1;
        logic                    tx_s1v;
        logic [31:0]             tx_s2;
        logic                    tx_s2v;
        logic [31:0]             prev1;
        logic [31:0]             prev2;
        sync_state_type          sync;
        logic [5:0]              ofs;
        logic [2:0]              skp_groups;
        logic                    skp_err;
        logic [DEPTH-1:0][32:0]  mem;
        logic [AW-1:0]           wp;
        logic [AW-1:0]           rp;
        logic [AW:0]             cnt;
        logic                    inserted;
        logic [31:0]             rm_word;
        logic                    rm_v;
        logic [31:0]             rx_word;
        logic                    rx_v;
        rate_type                rate;
        logic                    ltr;
        logic                    idle_d;
        loopback_type            lb;
        core_fifo_mode_type      fmode;
        logic [15:0]             ins_cnt;
        logic [15:0]             drop_cnt;
        logic [31:0]             prdata;
    } state_type;

    state_type st_reg;
    state_type st_next;

    // Address decode shared by the read capture and the write path.
    // Bit 2 flags a mapped address; a plain return keeps it usable in an assign.
    function automatic logic [2:0] reg_index(input logic [11:0] addr);
        case (addr)
            CTRL_OFS:   reg_index = 3'h4;
            STATUS_OFS: reg_index = 3'h5;
            RMCNT_OFS:  reg_index = 3'h6;
            default:    reg_index = 3'h0;
        endcase
    endfunction

    // Lowest bit position that holds a boundary candidate.
    function automatic logic [4:0] first_index(input logic [31:0] v);
        first_index = 5'h00;
        for (int i = 31; i >= 0; i--) begin
            if (v[i]) begin
                first_index = 5'(i);
            end
        end
    endfunction

    // Receive search window over the two previous words and the new one.
    logic [95:0] win;
    logic [31:0] os_hit;
    logic        any_hit;
    logic [5:0]  hit_ofs;
    logic [5:0]  cur_ofs;
    logic [31:0] aligned;
    assign win = {rx_pma_data_i, st_reg.prev1, st_reg.prev2};

    // Each of the 32 bit positions of the oldest word is checked in parallel for an ordered set start.
    genvar k;
    generate
        for (k = 0; k < 32; k++) begin : g_search
            assign os_hit[k] = (win[k +: 2] == SYNC_OS) &&                              // [RL8]
                               ((win[k + 2 +: 8] == SKP_SYM) ||
                                ((win[k + 2 +: 8] == EIEOS_SYM0) &&
                                 (win[k + 10 +: 8] == EIEOS_SYM1)));
        end
    endgenerate

    assign any_hit = rx_pma_valid_i && (|os_hit);
    assign hit_ofs = {1'b0, first_index(os_hit)} + 6'h02;
    assign cur_ofs = any_hit ? hit_ofs : st_reg.ofs;  // Realign in the hit cycle, losing no word.
    assign aligned = win[cur_ofs +: 32];

    // Rate match and sync decisions used by the state update and checks.
    logic        locked;
    logic        word_skp;
    logic        word_end;
    logic        wr_req;
    logic        drop;
    logic        head_skp;
    logic        insert;
    logic        rd;
    assign locked   = (st_reg.sync == SYNC_LOCKED);
    assign word_skp = (aligned == {4{SKP_SYM}});                                        // [RL11]
    assign word_end = (aligned[7:0] == SKP_END_SYM);
    assign wr_req   = (locked || any_hit) && rx_pma_valid_i;
    assign drop     = wr_req && word_skp && (st_reg.cnt >= (AW+1)'(NEAR_FULL));         // [RL12]
    assign head_skp = st_reg.mem[st_reg.rp][32];
    assign insert   = (st_reg.cnt != '0) && (st_reg.cnt <= (AW+1)'(NEAR_EMPTY)) &&
                      head_skp && !st_reg.inserted;                                     // [RL13]
    assign rd       = (st_reg.cnt != '0) && !insert;

    logic        apb_setup;
    logic        apb_access;
    logic        rd_hit;
    logic        wr_hit;
    logic [1:0]  rd_idx;
    logic [1:0]  wr_idx;
    assign apb_setup  = apb_i.psel && !apb_i.penable;
    assign apb_access = apb_i.psel && apb_i.penable;
    assign {rd_hit, rd_idx} = reg_index(apb_i.paddr);
    assign {wr_hit, wr_idx} = reg_index(apb_i.paddr);

    // Next-state logic for the whole block.
    always_comb begin
        logic [63:0] push;
        logic [63:0] tmp;
        logic        err_set;
        push    = '0;
        tmp     = '0;
        err_set = 1'b0;
        st_next = st_reg;

        // Transmit gearbox: header rides in the low bits of the first word.
        st_next.gb_v = 1'b0;
        if (tx_data_valid_i) begin
            if (st_reg.widx == 2'h0) begin
                push = {30'h0, tx_data_i, tx_sync_hdr_i};                               // [RL2]
            end else begin
                push = {32'h0, tx_data_i};
            end
            tmp             = st_reg.acc | (push << st_reg.fill);                       // [RL3]
            st_next.gb_word = tmp[31:0];                                                // [RL1]
            st_next.gb_v    = 1'b1;
            st_next.acc     = tmp >> 32;
            st_next.widx    = st_reg.widx + 2'h1;
            if (st_reg.widx == 2'h0) begin
                st_next.fill = st_reg.fill + BLOCK_SHIFT;                               // [RL4]
            end
        end else if (st_reg.fill == GAP_FILL) begin
            // The gap drains the whole extra word and restarts alignment.
            st_next.gb_word = st_reg.acc[31:0];                                         // [RL21]
            st_next.gb_v    = 1'b1;
            st_next.acc     = '0;
            st_next.fill    = '0;
            st_next.widx    = 2'h0;
        end

        // Fixed PCS stage, then an optional core stage chosen by mode.
        st_next.tx_s1  = st_reg.gb_v ? st_reg.gb_word : st_reg.tx_s1;                   // [RL6]
        st_next.tx_s1v = st_reg.gb_v;
        st_next.tx_s2  = st_reg.tx_s1;                                                  // [RL7]
        st_next.tx_s2v = st_reg.tx_s1v;

        // Block synchronizer: realign on every boundary candidate.
        if (rx_pma_valid_i) begin
            st_next.prev2 = st_reg.prev1;
            st_next.prev1 = rx_pma_data_i;
        end
        if (any_hit) begin
            st_next.sync       = SYNC_LOCKED;                                           // [RL9]
            st_next.ofs        = hit_ofs;
            st_next.skp_groups = {2'h0, word_skp};
        end else if (wr_req) begin
            if (word_skp) begin
                st_next.skp_groups = st_reg.skp_groups + 3'h1;
            end else if (word_end && (st_reg.skp_groups != '0)) begin
                // END symbol then 24 LFSR bits close the fixed 34-bit part.
                err_set = (st_reg.skp_groups < SKP_GROUPS_MIN) ||
                          (st_reg.skp_groups > SKP_GROUPS_MAX);                         // [RL10]
                st_next.skp_groups = '0;
            end
        end

        // Rate match FIFO with SKP drop and insert.
        if (wr_req && !drop) begin
            st_next.mem[st_reg.wp] = {word_skp, aligned};
            st_next.wp = st_reg.wp + AW'(1);
        end
        if (drop) begin
            st_next.drop_cnt = st_reg.drop_cnt + 16'h0001;
        end
        st_next.rm_v = rd || insert;
        if (insert) begin
            st_next.rm_word  = {4{SKP_SYM}};
            st_next.inserted = 1'b1;
            st_next.ins_cnt  = st_reg.ins_cnt + 16'h0001;
        end else if (rd) begin
            st_next.rm_word = st_reg.mem[st_reg.rp][31:0];
            st_next.rp      = st_reg.rp + AW'(1);
            if (!head_skp) begin
                st_next.inserted = 1'b0;
            end
        end
        st_next.cnt = st_reg.cnt + (AW+1)'(wr_req && !drop) - (AW+1)'(rd);

        // Receive core stage toward the fabric.
        st_next.rx_word = st_reg.rm_v ? st_reg.rm_word : st_reg.rx_word;                // [RL14]
        st_next.rx_v    = st_reg.rm_v;

        // Rate follows any legal request from the MAC.
        if (pipe_rate_i != 2'b11) begin
            st_next.rate = rate_type'(pipe_rate_i);                                     // [RL15]
        end

        // CDR control for fast L0s exit, Gen3 only.
        st_next.idle_d = rx_elec_idle_i;
        if (st_reg.rate != RATE_GEN3) begin
            st_next.ltr = 1'b0;
        end else if (wr_req && (aligned == {4{EIOS_SYM}})) begin
            st_next.ltr = 1'b1;                                                         // [RL16]
        end else if (st_reg.idle_d && !rx_elec_idle_i) begin
            st_next.ltr = 1'b0;                                                         // [RL16]
        end

        // APB: read data captured in setup, writes land in access.
        if (apb_setup) begin
            case (rd_idx)
                2'h0:    st_next.prdata = {28'h0, st_reg.fmode, st_reg.lb};
                2'h1:    st_next.prdata = {27'h0, st_reg.skp_err, st_reg.ltr,
                                           locked, st_reg.rate};
                default: st_next.prdata = {st_reg.drop_cnt, st_reg.ins_cnt};
            endcase
            if (!rd_hit) begin
                st_next.prdata = '0;
            end
        end
        if (apb_access && apb_i.pwrite && wr_hit) begin
            if (wr_idx == 2'h0) begin
                st_next.lb    = loopback_type'(apb_i.pwdata[1:0]);                      // [RL20]
                st_next.fmode = (apb_i.pwdata[3:2] == 2'b11) ? st_reg.fmode :
                                core_fifo_mode_type'(apb_i.pwdata[3:2]);
            end else if (wr_idx == 2'h1 && apb_i.pwdata[STS_ERR_BIT]) begin
                st_next.skp_err = 1'b0;
            end
        end
        // A length error in the clearing cycle still sets the flag.
        if (err_set) begin
            st_next.skp_err = 1'b1;
        end

        if (!reset_n_i) begin
            st_next       = '0;
            st_next.sync  = SYNC_HUNT;
            st_next.rate  = RATE_RESET;
            st_next.lb    = LB_RESET;
            st_next.fmode = FMODE_RESET;
        end
    end

    // Single state register; reset is folded into the next value.
    always_ff @(posedge sys_clk_i) begin
        st_reg <= st_next;
    end

    // Outputs.
    assign prdata_o          = st_reg.prdata;
    assign pready_o          = 1'b1;
    assign pslverr_o         = apb_access && !wr_hit;
    assign tx_pma_data_o     = (st_reg.fmode == FM_REGISTER) ? st_reg.tx_s1 : st_reg.tx_s2;
    assign tx_pma_valid_o    = (st_reg.fmode == FM_REGISTER) ? st_reg.tx_s1v : st_reg.tx_s2v;
    assign rx_data_o         = st_reg.rx_word;
    assign rx_valid_o        = st_reg.rx_v;
    assign rx_locked_o       = locked;
    assign rate_o            = st_reg.rate;
    assign cdr_lock_to_ref_o = st_reg.ltr;

    // Loopback muxes; the transmit buffer keeps sending in serial mode.
    assign cdr_in_o = (st_reg.lb == LB_SERIAL) ? ser_bit_i : rx_pin_i;                  // [RL17]
    assign tx_buf_o = (st_reg.lb == LB_POST_REV) ? cdr_bit_i :                          // [RL18]
                      (st_reg.lb == LB_PRE_REV)  ? rx_pin_i : ser_bit_i;

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!reset_n_i);

    a_gap_flush: assert property (!tx_data_valid_i && st_reg.fill == GAP_FILL |=> // [RL21]
        st_reg.gb_v && st_reg.fill == 6'h00 && st_reg.widx == 2'h0)
        else $error("gap cycle did not flush the extra word");
    a_block_shift: assert property (tx_data_valid_i && st_reg.widx == 2'h0 ##1 // [RL4]
        tx_data_valid_i [*3] |=> st_reg.fill == $past(st_reg.fill, 4) + BLOCK_SHIFT)
        else $error("block did not add two bits of alignment");
    a_gap_idle: assert property (!tx_data_valid_i && st_reg.fill != GAP_FILL |=> // [RL5]
        !st_reg.gb_v) else $error("gearbox emitted a word without input");
    a_word_order: assert property (tx_data_valid_i && st_reg.widx == LAST_WORD_IDX |=> // [RL2]
        st_reg.widx == 2'h0) else $error("block word counter out of step");
    a_skp_drop: assert property (drop && !rd |=> st_reg.cnt == $past(st_reg.cnt)) // [RL12]
        else $error("SKP word written while nearly full");
    a_skp_insert: assert property (insert |=> st_reg.rm_v && // [RL13]
        st_reg.rm_word == {4{SKP_SYM}} && $stable(st_reg.rp))
        else $error("SKP insert did not pause the read side");
    a_realign: assert property (any_hit |=> locked && st_reg.ofs == $past(hit_ofs)) // [RL9]
        else $error("synchronizer did not realign on boundary");
    a_cdr_ltr: assert property (st_reg.rate == RATE_GEN3 && wr_req && // [RL16]
        aligned == {4{EIOS_SYM}} |=> cdr_lock_to_ref_o)
        else $error("EIOS did not force reference lock");
    a_rate_follow: assert property (pipe_rate_i != 2'b11 ##1 1'b1 |-> // [RL15]
        rate_o == $past(pipe_rate_i)) else $error("rate did not follow request");
    a_serial_lb: assert property (st_reg.lb == LB_SERIAL |-> // [RL17]
        cdr_in_o == ser_bit_i && tx_buf_o == ser_bit_i)
        else $error("serial loopback path wrong");
    a_post_rev: assert property (st_reg.lb == LB_POST_REV |-> tx_buf_o == cdr_bit_i) // [RL18]
        else $error("post-CDR reverse loopback path wrong");

endmodule

/* gen3_pcs_pkg.sv */
// Purpose: Shared constants and types for the Gen3 PCS datapath block.
// Assumes: One 250 MHz clock, APB register access with 32-bit data.
// Notes:   Register offsets are byte addresses, one aligned word each.
package gen3_pcs_pkg;

    // Datapath geometry.
    localparam int unsigned WORD_W         = 32;
    localparam int unsigned HDR_W          = 2;
    localparam logic [5:0]  GAP_FILL       = 6'h20;  // Bits held after sixteen 2-bit shifts.
    localparam logic [5:0]  BLOCK_SHIFT    = 6'h02;
    localparam logic [1:0]  LAST_WORD_IDX  = 2'h3;

    // Ordered set symbols and header seen on the receive side.
    localparam logic [1:0]  SYNC_OS        = 2'h1;
    localparam logic [7:0]  SKP_SYM        = 8'hAA;
    localparam logic [7:0]  SKP_END_SYM    = 8'hE1;
    localparam logic [7:0]  EIOS_SYM       = 8'h66;
    localparam logic [7:0]  EIEOS_SYM0     = 8'h00;
    localparam logic [7:0]  EIEOS_SYM1     = 8'hFF;
    localparam logic [2:0]  SKP_GROUPS_MIN = 3'h1;   // 66-bit set.
    localparam logic [2:0]  SKP_GROUPS_MAX = 3'h5;   // 194-bit set.

    // Register map.
    localparam logic [11:0] CTRL_OFS       = 12'h000;
    localparam logic [11:0] STATUS_OFS     = 12'h004;
    localparam logic [11:0] RMCNT_OFS      = 12'h008;
    localparam int unsigned STS_ERR_BIT    = 4;

    typedef enum logic [1:0] {
        LB_NONE     = 2'b00,
        LB_SERIAL   = 2'b01,
        LB_PRE_REV  = 2'b10,
        LB_POST_REV = 2'b11
    } loopback_type;

    typedef enum logic [1:0] {
        FM_PHASE    = 2'b00,
        FM_REGISTER = 2'b01,
        FM_BASIC    = 2'b10
    } core_fifo_mode_type;

    typedef enum logic [1:0] {
        RATE_GEN1 = 2'b00,
        RATE_GEN2 = 2'b01,
        RATE_GEN3 = 2'b10
    } rate_type;

    typedef enum logic {
        SYNC_HUNT   = 1'b0,
        SYNC_LOCKED = 1'b1
    } sync_state_type;

    localparam loopback_type       LB_RESET    = LB_NONE;
    localparam core_fifo_mode_type FMODE_RESET = FM_PHASE;
    localparam rate_type           RATE_RESET  = RATE_GEN1;

    // APB request from the master.
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } apb_req_type;

endpackage

/* gen3_pcs_mac_model.sv */
// Purpose: Transmit side of the MAC that feeds the gearbox.
// Assumes: Driven on the rising edge; start_i is a level.
// Notes:   Sends sixteen blocks, then the one-cycle gap, then stops.
`timescale 1ns/100ps
module gen3_pcs_mac_model (
    input  wire logic        clk_i,
    input  wire logic        start_i,
    output logic [31:0]      data_o,
    output logic [1:0]       hdr_o,
    output logic             valid_o,
    output logic             done_o
);
    logic [6:0] cyc;
    // Idle data toggles so a stale word never looks valid.
    initial begin
        cyc     = 7'h00;
        data_o  = 32'h0;
        hdr_o   = 2'h0;
        valid_o = 1'b0;
        done_o  = 1'b0;
    end
    // Four words per block, header on the first one; pre-emphasis taps do not exist here.
    always @(posedge clk_i) begin
        if (start_i && !done_o && cyc < 7'h40) begin
            valid_o <= 1'b1;
            data_o  <= {8'hC3, 4'h0, cyc[5:2], 6'h00, cyc[1:0], 8'h5A};
            hdr_o   <= cyc[2] ? 2'h2 : 2'h1;
            cyc     <= cyc + 7'h01;
        end else begin
            valid_o <= 1'b0;
            data_o  <= ~data_o;
            done_o  <= done_o | (cyc == 7'h40);
        end
    end
endmodule

/* gen3_pcs_datapath_tb.sv */
// Purpose: Self-checking bench for the Gen3 PCS datapath.
// Assumes: APB slave may stretch the access; gearbox latency is not fixed here.
// Notes:   Rate-match depth effects are checked only through the RMCNT drop and insert counters.
`timescale 1ns/100ps
module gen3_pcs_datapath_tb;
    import gen3_pcs_pkg::*;
    logic sys_clk_i, reset_n_i, tx_valid, start, done, rx_valid, idle, ser, pin, cdr;
    logic pready_o, pslverr_o, tx_pma_valid_o, rx_valid_o, rx_locked_o;
    logic lock_ref, cdr_in_o, tx_buf_o;
    logic [1:0]  pipe_rate_i, hdr, rate_o;
    logic [31:0] prdata_o, tx_data, tx_pma_data_o, rx_word, rx_data_o, rd;
    apb_req_type apb;
    int unsigned failures, n_compared, seen_eios;
    logic err;
    logic q[$];

    gen3_pcs_datapath dut (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .apb_i(apb),
        .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
        .pipe_rate_i(pipe_rate_i), .tx_data_i(tx_data), .tx_sync_hdr_i(hdr),
        .tx_data_valid_i(tx_valid), .tx_pma_data_o(tx_pma_data_o),
        .tx_pma_valid_o(tx_pma_valid_o), .rx_pma_data_i(rx_word), .rx_pma_valid_i(rx_valid),
        .rx_elec_idle_i(idle), .rx_data_o(rx_data_o), .rx_valid_o(rx_valid_o),
        .rx_locked_o(rx_locked_o), .rate_o(rate_o), .cdr_lock_to_ref_o(lock_ref),
        .ser_bit_i(ser), .rx_pin_i(pin), .cdr_bit_i(cdr), .cdr_in_o(cdr_in_o),
        .tx_buf_o(tx_buf_o));
    gen3_pcs_mac_model mac (.clk_i(sys_clk_i), .start_i(start), .data_o(tx_data), .hdr_o(hdr),
        .valid_o(tx_valid), .done_o(done));

    // Clock at 250 MHz.
    initial begin
        sys_clk_i = 1'b0;
        forever #2 sys_clk_i = ~sys_clk_i;
    end
    // Count aligned idle-set words leaving the receive path.
    always @(negedge sys_clk_i) if (rx_valid_o === 1'b1 && rx_data_o === 32'h66666666) seen_eios++;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One APB transfer; the request holds until pready is seen high.
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int unsigned k;
        @(posedge sys_clk_i);
        apb <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
        @(posedge sys_clk_i);
        apb.penable <= 1'b1;
        k = 0;
        do begin
            @(posedge sys_clk_i);
            k++;
        end while (pready_o !== 1'b1 && k < 50);
        rd = prdata_o;
        err = pslverr_o;
        apb.psel <= 1'b0;
        apb.penable <= 1'b0;
        if (k >= 50) failures++;
    endtask
    task automatic put(input logic [7:0] v, input int n);
        for (int i = 0; i < n; i++) q.push_back(v[i]);
    endtask

    task automatic t_regs;
        xfer(1'b0, CTRL_OFS, 32'h0);
        chk(rd, 32'h0);
        xfer(1'b0, STATUS_OFS, 32'h0);
        chk(rd, 32'h0);
        xfer(1'b0, 12'h00C, 32'h0);
        chk({31'h0, err}, 32'h1);
        for (int m = 1; m < 4; m++) begin
            xfer(1'b1, CTRL_OFS, 32'(m) << 2);
            xfer(1'b0, CTRL_OFS, 32'h0);
            chk({30'h0, rd[3:2]}, (m == 3) ? 32'h2 : 32'(m));
        end
    endtask
    // Every loopback setting against every combination of the three bits.
    task automatic t_loop;
        logic [1:0] e;
        for (int l = 0; l < 4; l++) begin
            xfer(1'b1, CTRL_OFS, 32'(l));
            for (int b = 0; b < 8; b++) begin
                @(posedge sys_clk_i);
                {ser, pin, cdr} <= 3'(b);
                @(negedge sys_clk_i);
                e[1] = (l == 1) ? ser : pin;
                e[0] = (l == 3) ? cdr : (l == 2) ? pin : ser;
                chk({cdr_in_o, tx_buf_o}, {30'h0, e});
            end
        end
        xfer(1'b1, CTRL_OFS, 32'h0);
    endtask
    task automatic t_rate;
        for (int r = 0; r < 4; r++) begin
            pipe_rate_i <= 2'(r);
            repeat (20) @(posedge sys_clk_i);
            chk({30'h0, rate_o}, (r == 3) ? 32'h2 : 32'(r));
        end
        xfer(1'b0, STATUS_OFS, 32'h0);
        chk({30'h0, rd[1:0]}, 32'h2);
    endtask
    // Sixteen blocks make 2080 bits, header first and LSB first: 65 words.
    task automatic t_tx;
        logic [2079:0] s;
        int unsigned n, w;
        for (int b = 0; b < 16; b++) begin
            s[130*b +: 2] = b[0] ? 2'h2 : 2'h1;
            for (int k = 0; k < 4; k++)
                s[130*b+2+32*k +: 32] = {8'hC3, 4'h0, 4'(b), 6'h00, 2'(k), 8'h5A};
        end
        start <= 1'b1;
        n = 0;
        w = 0;
        while (w < 300) begin
            @(negedge sys_clk_i);
            w++;
            if (tx_pma_valid_o === 1'b1) begin
                if (n < 65) chk(tx_pma_data_o, s[32*n +: 32]);
                n++;
            end
        end
        chk(n, 32'd65);
    endtask
    // Skewed start, three short skip sets, then idle sets at Gen3.
    task automatic t_rx;
        put(8'h13, 5);
        for (int i = 0; i < 3; i++) begin
            put(8'h01, 2);
            repeat (4) put(SKP_SYM, 8);
            put(SKP_END_SYM, 8);
            put(8'h12, 8); put(8'h34, 8); put(8'h56, 8);
        end
        for (int i = 0; i < 4; i++) begin
            put(8'h01, 2);
            repeat (16) put(EIOS_SYM, 8);
        end
        while (q.size() >= 32) begin
            @(posedge sys_clk_i);
            rx_valid <= 1'b1;
            for (int i = 0; i < 32; i++) rx_word[i] <= q.pop_front();
        end
        @(posedge sys_clk_i);
        rx_valid <= 1'b0;
        rx_word <= 32'h5A5A5A5A;
        repeat (10) @(posedge sys_clk_i);
        chk({31'h0, rx_locked_o}, 32'h1);
        chk({31'h0, lock_ref}, 32'h1);
        chk({31'h0, 1'(seen_eios > 0)}, 32'h1);
        xfer(1'b0, STATUS_OFS, 32'h0);
        chk({27'h0, rd[STS_ERR_BIT:2]}, 32'h3);
        // The FIFO starts empty with a skip word at its head, so an insert is due;
        // words arrive at the read rate, so it never nears full and nothing drops.
        xfer(1'b0, RMCNT_OFS, 32'h0);
        chk({16'h0, rd[31:16]}, 32'h0);
        chk({31'h0, 1'(rd[15:0] != 16'h0)}, 32'h1);
        idle <= 1'b1;
        repeat (3) @(posedge sys_clk_i);
        idle <= 1'b0;
        repeat (10) @(posedge sys_clk_i);
        chk({31'h0, lock_ref}, 32'h0);
    endtask

    task automatic wrap_up;
        if (failures == 0 && n_compared > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // Watchdog sized well beyond the few hundred cycles the tests need.
    initial begin
        repeat (20000) @(posedge sys_clk_i);
        failures++;
        wrap_up();
    end
    initial begin
        apb = '0;
        {reset_n_i, start, rx_valid, idle, ser, pin, cdr} = 7'h0;
        pipe_rate_i = 2'h0;
        rx_word = 32'h0;
        repeat (12) @(posedge sys_clk_i);
        reset_n_i <= 1'b1;
        t_regs();
        t_loop();
        t_rate();
        t_tx();
        t_rx();
        wrap_up();
    end
endmodule
